//--- rtl/event_flag_bank.sv
/*
  Sticky event-flag bank of the second latched status word, with the
  overcurrent phase register, per-phase idle register, configuration checksum
  engine and start-up sequencer that feed it.
  Assumes event inputs are one-cycle pulses and condition inputs are levels,
  all synchronous to i_sys_clk; the register port is driven by the serial
  interface engine with one-cycle read and write strobes.
*/
// Summary of operation
// - checksum finish after force sets bit 27
// - config change recomputes checksum, sets bit 26
// - sag entry or exit sets per-phase flag
// - overvoltage entry or exit sets per-phase flag
// - wrong zero-crossing order sets bit 18
// - overcurrent sets bit 17, phases recorded
// - start-up finish sets bit 16
// - current zero-crossing sets per-phase flag
// - combined voltage zero-crossing sets bit 12
// - voltage zero-crossing sets per-phase flag
// - missing voltage zero-crossing sets timeout flag
// - idle entry or exit sets bit 5
`include "flag_bank_map.svh"
`default_nettype none

module event_flag_bank #(
  parameter int CFG_WORDS = `CFG_WORDS_DFLT,
  parameter int WORD_W = `WORD_W_DFLT,
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES_DFLT
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  input wire logic [CFG_WORDS*WORD_W-1:0] i_cfg_image,
  input wire logic [2:0] i_sag_level,
  input wire logic [2:0] i_overvolt_level,
  input wire logic [2:0] i_idle_level,
  input wire logic i_phase_order_err,
  input wire logic [2:0] i_overcurrent_evt,
  input wire flag_bank_pkg::power_mode_t i_power_mode,
  input wire logic [2:0] i_curr_zx,
  input wire logic i_comb_zx,
  input wire logic [2:0] i_volt_zx,
  input wire logic [2:0] i_zx_timeout,
  output logic [31:0] o_event_flags,
  output logic o_startup_busy
);
  localparam int IDX_W = (CFG_WORDS > 1) ? $clog2(CFG_WORDS) : 1;
  localparam int SU_W = $clog2(STARTUP_CYCLES + 1);

  // Checksum step: rotate and fold in the next word
  function automatic logic [WORD_W-1:0] ck_mix(input logic [WORD_W-1:0] acc,
                                               input logic [WORD_W-1:0] word);
    ck_mix = {acc[WORD_W-2:0], acc[WORD_W-1]} ^ word;
  endfunction

  logic [31:0] flags;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [2:0] oc_phase;
  logic [8:0] cond_change;
  logic [8:0] cond_q;
  logic [31:0] rd_mux;

  // Register port decode
  wire sel_flags = i_reg_addr == `ADDR_FLAGS;
  wire sel_oc = i_reg_addr == `ADDR_OC_PHASE;
  wire sel_idle = i_reg_addr == `ADDR_IDLE_PHASE;
  wire sel_result = i_reg_addr == `ADDR_CK_RESULT;
  wire wr_flags = i_reg_wr && sel_flags;
  wire wr_oc = i_reg_wr && sel_oc;
  wire wr_force = i_reg_wr && (i_reg_addr == `ADDR_CK_FORCE) && i_reg_wdata[`BIT_FORCE_UPD];

  // Condition levels: sag, overvoltage and idle per phase, both edges count
  change_detect #(
    .WIDTH(9)
  ) u_cond_edges (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_level({i_idle_level, i_overvolt_level, i_sag_level}),
    .o_change(cond_change),
    .o_level_q(cond_q)
  );

  wire [2:0] sag_chg = cond_change[2:0];
  wire [2:0] ovolt_chg = cond_change[5:3];
  wire [2:0] idle_chg = cond_change[8:6];

  // ---- Configuration checksum engine ----
  flag_bank_pkg::ck_state_t ck_state;
  logic [IDX_W-1:0] ck_idx;
  logic [WORD_W-1:0] ck_acc;
  logic [WORD_W-1:0] cfg_check_result_reg;
  logic [CFG_WORDS*WORD_W-1:0] cfg_prev;
  logic cfg_seen;
  logic pend_force;
  logic pend_chg;
  logic run_force;
  logic run_chg;

  // Watch the covered registers; first cycle after reset only primes the copy
  wire cfg_moved = cfg_seen && (cfg_prev != i_cfg_image);
  wire [WORD_W-1:0] ck_word = i_cfg_image[ck_idx*WORD_W +: WORD_W];
  wire [WORD_W-1:0] ck_next = ck_mix(ck_acc, ck_word);
  wire ck_last = ck_idx == IDX_W'(CFG_WORDS - 1);
  wire ck_running = ck_state == flag_bank_pkg::ck_run;
  wire ck_start = !ck_running && (pend_force || pend_chg);
  wire ck_fin = ck_running && ck_last;

  // Change tracking and pending requests; requests during a run queue up
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cfg_prev <= '0;
      cfg_seen <= 1'b0;
      pend_force <= 1'b0;
      pend_chg <= 1'b0;
    end else if (i_clk_en) begin
      cfg_prev <= i_cfg_image;
      cfg_seen <= 1'b1;
      pend_force <= wr_force || (pend_force && !ck_start);
      pend_chg <= cfg_moved || (pend_chg && !ck_start);
    end
  end

  // Word-serial checksum walk, one word per enabled cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ck_state <= flag_bank_pkg::ck_idle;
      ck_idx <= '0;
      ck_acc <= '0;
      run_force <= 1'b0;
      run_chg <= 1'b0;
      cfg_check_result_reg <= '0;
    end else if (i_clk_en) begin
      case (ck_state)
        flag_bank_pkg::ck_idle: begin
          if (ck_start) begin
            ck_state <= flag_bank_pkg::ck_run;
            ck_idx <= '0;
            ck_acc <= WORD_W'(`CK_SEED);
            run_force <= pend_force;
            run_chg <= pend_chg;
          end
        end
        flag_bank_pkg::ck_run: begin
          ck_acc <= ck_next;
          ck_idx <= ck_idx + 1'b1;
          if (ck_last) begin
            ck_state <= flag_bank_pkg::ck_idle;
            cfg_check_result_reg <= ck_next;
          end
        end
        default: ck_state <= flag_bank_pkg::ck_idle;
      endcase
    end
  end

  // ---- Start-up sequencer: after reset and on a step from lowest power to full operation ----
  flag_bank_pkg::power_mode_t mode_prev;
  logic su_busy;
  logic [SU_W-1:0] su_cnt;

  wire su_wake = (mode_prev == flag_bank_pkg::lowest_power_mode) &&
                 (i_power_mode == flag_bank_pkg::full_operation_mode);
  wire su_last = su_cnt == SU_W'(STARTUP_CYCLES - 1);
  wire su_fire = i_clk_en && su_busy && su_last && !su_wake;

  // Count the start-up time, restarting on every wake
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mode_prev <= flag_bank_pkg::full_operation_mode;
      su_busy <= 1'b1;
      su_cnt <= '0;
    end else if (i_clk_en) begin
      mode_prev <= i_power_mode;
      if (su_wake) begin
        su_busy <= 1'b1;
        su_cnt <= '0;
      end else if (su_busy) begin
        su_busy <= !su_last;
        su_cnt <= su_cnt + 1'b1;
      end
    end
  end

  // ---- Flag set vector, one field per event source ----
  assign set_vec[31:28] = 4'h0;
  assign set_vec[`BIT_CK_DONE] = ck_fin && run_force;
  assign set_vec[`BIT_CFG_CHG] = ck_fin && run_chg;
  assign set_vec[`LSB_SAG +: 3] = sag_chg;
  assign set_vec[`LSB_OVOLT +: 3] = ovolt_chg;
  assign set_vec[`BIT_RSVD] = 1'b0;
  assign set_vec[`BIT_ORDER_ERR] = i_phase_order_err;
  assign set_vec[`BIT_OVERCUR] = |i_overcurrent_evt;
  assign set_vec[`BIT_PWRUP] = su_fire;
  assign set_vec[`LSB_CURR_ZX +: 3] = i_curr_zx;
  assign set_vec[`BIT_COMB_ZX] = i_comb_zx;
  assign set_vec[`LSB_VOLT_ZX +: 3] = i_volt_zx;
  assign set_vec[`LSB_ZX_TMO +: 3] = i_zx_timeout;
  assign set_vec[`BIT_IDLE] = |idle_chg;
  assign set_vec[4:0] = 5'h00;

  // Write-one-to-clear; zero bits leave flags alone
  assign clr_vec = wr_flags ? i_reg_wdata : `FLAGS_RESET;

  // Latched flag word, reserved and excluded bits held at zero
  w1c_flags #(
    .WIDTH(32),
    .MASK(`FLAG_IMPL_MASK)
  ) u_flags (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_set(set_vec),
    .i_clr(clr_vec),
    .o_flags(flags)
  );

  // Which phases raised an overcurrent, cleared the same way
  w1c_flags #(
    .WIDTH(3),
    .MASK(`PHASE_MASK)
  ) u_oc_phase (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_set(i_overcurrent_evt),
    .i_clr(wr_oc ? i_reg_wdata[2:0] : 3'h0),
    .o_flags(oc_phase)
  );

  // Read data selection; unmapped addresses read zero
  assign rd_mux = sel_flags ? flags :
                  sel_oc ? {29'h0000_0000, oc_phase} :
                  sel_idle ? {29'h0000_0000, cond_q[8:6]} :
                  sel_result ? 32'(cfg_check_result_reg) :
                  32'h0000_0000;

  // Registered read data
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_clk_en && i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

  assign o_event_flags = flags;
  assign o_startup_busy = su_busy;

  // ---- Checks ----
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_ck_done_flag: assert property (
    i_clk_en && ck_fin && run_force |=> flags[`BIT_CK_DONE])
    else $error("checksum done flag not set");
  a_cfg_chg_result: assert property (
    i_clk_en && ck_fin && run_chg
      |=> flags[`BIT_CFG_CHG] && cfg_check_result_reg == $past(ck_next))
    else $error("change flag or result missing");
  a_sag_edges: assert property (
    i_clk_en && |sag_chg |=> (flags & $past(set_vec) & `MSK_SAG) == ($past(set_vec) & `MSK_SAG))
    else $error("sag flag not set");
  a_ovolt_edges: assert property (
    i_clk_en && |ovolt_chg
      |=> (flags & $past(set_vec) & `MSK_OVOLT) == ($past(set_vec) & `MSK_OVOLT))
    else $error("overvoltage flag not set");
  a_order_err_flag: assert property (
    i_clk_en && i_phase_order_err |=> flags[`BIT_ORDER_ERR])
    else $error("phase order flag not set");
  a_overcur_phase: assert property (
    i_clk_en && |i_overcurrent_evt
      |=> flags[`BIT_OVERCUR] && (oc_phase & $past(i_overcurrent_evt)) == $past(i_overcurrent_evt))
    else $error("overcurrent flag or phase missing");
  a_startup_time: assert property (
    $rose(su_busy) ##1 i_clk_en [*8] |-> !flags[`BIT_PWRUP] || $past(flags[`BIT_PWRUP], 9))
    else $error("start-up flag too early");
  a_pwrup_flag: assert property (
    su_fire |=> flags[`BIT_PWRUP] && !su_busy)
    else $error("start-up flag not set");
  a_curr_zx_flag: assert property (
    i_clk_en && |i_curr_zx
      |=> (flags & $past(set_vec) & `MSK_CURR_ZX) == ($past(set_vec) & `MSK_CURR_ZX))
    else $error("current crossing flag not set");
  a_comb_zx_flag: assert property (
    i_clk_en && i_comb_zx |=> flags[`BIT_COMB_ZX])
    else $error("combined crossing flag not set");
  a_volt_zx_flag: assert property (
    i_clk_en && |i_volt_zx
      |=> (flags & $past(set_vec) & `MSK_VOLT_ZX) == ($past(set_vec) & `MSK_VOLT_ZX))
    else $error("voltage crossing flag not set");
  a_zx_tmo_flag: assert property (
    i_clk_en && |i_zx_timeout
      |=> (flags & $past(set_vec) & `MSK_ZX_TMO) == ($past(set_vec) & `MSK_ZX_TMO))
    else $error("crossing timeout flag not set");
  a_idle_flag: assert property (
    i_clk_en && |idle_chg |=> flags[`BIT_IDLE] && cond_q[8:6] == $past(i_idle_level))
    else $error("idle flag or phases wrong");
  a_clear_only_ones: assert property (
    i_clk_en && wr_flags
      |=> ((flags ^ $past(flags)) & ~$past(i_reg_wdata) & ~$past(set_vec)) == 32'h0000_0000
          && (flags & $past(i_reg_wdata) & ~$past(set_vec)) == 32'h0000_0000)
    else $error("write-one-to-clear misbehaved");
  a_freeze_hold: assert property (
    !i_clk_en |=> flags == $past(flags) && ck_state == $past(ck_state))
    else $error("state moved while disabled");
  a_reset_zero: assert property (
    $past(i_sys_rst) |-> flags == `FLAGS_RESET && !flags[`BIT_RSVD])
    else $error("flags not zero after reset");

  c_force_done: cover property (wr_force ##[1:20] flags[`BIT_CK_DONE]);
  c_cfg_change: cover property (cfg_moved ##[1:20] flags[`BIT_CFG_CHG]);
  c_set_and_clr: cover property (i_clk_en && wr_flags && |(set_vec & i_reg_wdata));
  c_wake_done: cover property (su_wake ##[1:300] su_fire);
endmodule

`default_nettype wire

//--- rtl/flag_bank_map.svh
/*
  Register map, bit positions and timing constants of the sticky event-flag bank.
  Assumes a 20 MHz core clock; included by bare name from the rtl folder.
*/
`ifndef FLAG_BANK_MAP_SVH
`define FLAG_BANK_MAP_SVH

// Register addresses on the device's internal register port
`define ADDR_FLAGS 16'h0403
`define ADDR_OC_PHASE 16'h0410
`define ADDR_IDLE_PHASE 16'h0411
`define ADDR_CK_RESULT 16'h0412
`define ADDR_CK_FORCE 16'h0413

// Bit positions inside the flag word and the checksum force register
`define BIT_CK_DONE 27
`define BIT_CFG_CHG 26
`define LSB_SAG 23
`define LSB_OVOLT 20
`define BIT_RSVD 19
`define BIT_ORDER_ERR 18
`define BIT_OVERCUR 17
`define BIT_PWRUP 16
`define LSB_CURR_ZX 13
`define BIT_COMB_ZX 12
`define LSB_VOLT_ZX 9
`define LSB_ZX_TMO 6
`define BIT_IDLE 5
`define BIT_FORCE_UPD 0

// Field masks and reset values
`define FLAG_IMPL_MASK 32'h0FF7_FFE0
`define MSK_SAG 32'h0380_0000
`define MSK_OVOLT 32'h0070_0000
`define MSK_CURR_ZX 32'h0000_E000
`define MSK_VOLT_ZX 32'h0000_0E00
`define MSK_ZX_TMO 32'h0000_01C0
`define FLAGS_RESET 32'h0000_0000
`define PHASE_MASK 3'h7
`define CK_SEED 32'hFFFF_FFFF

// Sizes and timing
`define CFG_WORDS_DFLT 8
`define WORD_W_DFLT 32
`define CLK_PERIOD_NS 50
`define STARTUP_TIME_NS 100000
`define STARTUP_CYCLES_DFLT ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/flag_bank_pkg.sv
/*
  Types shared by the sticky event-flag bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package flag_bank_pkg;
  // Operating power modes, as presented by the power manager
  typedef enum logic [1:0] {
    full_operation_mode,
    reduced_mode,
    low_mode,
    lowest_power_mode
  } power_mode_t;

  // Checksum engine states
  typedef enum logic {ck_idle, ck_run} ck_state_t;
endpackage

`default_nettype wire

//--- rtl/change_detect.sv
/*
  Level-change detector: one-cycle pulse on either edge of each input bit.
  Assumes inputs synchronous to i_sys_clk.
*/
`default_nettype none

module change_detect #(
  parameter int WIDTH = 9
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_change,
  output logic [WIDTH-1:0] o_level_q
);
  logic [WIDTH-1:0] level_q;

  // Remember the last level seen
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      level_q <= '0;
    end else if (i_clk_en) begin
      level_q <= i_level;
    end
  end

  // Entry and exit both count as a change
  assign o_change = (i_level ^ level_q) & {WIDTH{i_clk_en}};
  assign o_level_q = level_q;
endmodule

`default_nettype wire

//--- rtl/w1c_flags.sv
/*
  Sticky flag register: hardware sets, a write of one clears, set beats clear.
  Assumes set and clear vectors synchronous to i_sys_clk.
*/
`default_nettype none

module w1c_flags #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic [WIDTH-1:0] i_clr,
  output logic [WIDTH-1:0] o_flags
);
  logic [WIDTH-1:0] flags;
  logic [WIDTH-1:0] next_flags;

  // Set wins over clear; unimplemented bits stay zero
  assign next_flags = ((flags & ~i_clr) | i_set) & MASK;

  // Flag storage
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flags <= '0;
    end else if (i_clk_en) begin
      flags <= next_flags;
    end
  end

  assign o_flags = flags;

  // A set in the clearing cycle still lands
  a_set_beats_clr: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_clk_en && |(i_set & i_clr & MASK)
      |=> (flags & $past(i_set & i_clr & MASK)) == $past(i_set & i_clr & MASK))
    else $error("set lost against a clear");
endmodule

`default_nettype wire

//--- tb/host_model.sv
/*
  Host processor model: drives the register port with one-cycle strobes.
  Assumes a single rising-edge clock shared with the flag bank.
*/
`default_nettype none

module host_model (
  input wire logic i_sys_clk,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [15:0] o_reg_addr,
  output logic [31:0] o_reg_wdata,
  input wire logic [31:0] i_reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus state before the first access
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 32'h0000_0000;
  end

  // One write; released address and data are inverted so stale values never match
  task automatic write(input logic [15:0] addr, input logic [31:0] data);
    @(posedge i_sys_clk);
    o_reg_addr <= addr;
    o_reg_wdata <= data;
    o_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~addr;
    o_reg_wdata <= ~data;
  endtask

  // One read; data is taken once the registered answer has settled
  task automatic read(input logic [15:0] addr, output logic [31:0] data);
    @(posedge i_sys_clk);
    o_reg_addr <= addr;
    o_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~addr;
    #1;
    data = i_reg_rdata;
  endtask
endmodule

`default_nettype wire

//--- tb/tb_top.sv
/*
  Self-checking bench of the sticky event-flag bank.
  Assumes the host model for register access and shortened start-up and checksum sizes.
*/
`include "flag_bank_map.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, clk_en, reg_wr, reg_rd, comb_zx, order_err;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, event_flags, r, r0, r1;
  logic [63:0] cfg_image;
  logic [2:0] sag, ovolt, idle, oc, curr_zx, volt_zx, zx_tmo;
  flag_bank_pkg::power_mode_t pmode;
  logic startup_busy;
  int fails, tests_run, k, p;

  event_flag_bank #(.CFG_WORDS(2), .WORD_W(32), .STARTUP_CYCLES(10)) dut_u (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .i_cfg_image(cfg_image), .i_sag_level(sag),
    .i_overvolt_level(ovolt), .i_idle_level(idle), .i_phase_order_err(order_err),
    .i_overcurrent_evt(oc), .i_power_mode(pmode), .i_curr_zx(curr_zx),
    .i_comb_zx(comb_zx), .i_volt_zx(volt_zx), .i_zx_timeout(zx_tmo),
    .o_event_flags(event_flags), .o_startup_busy(startup_busy)
  );

  host_model host_u (
    .i_sys_clk(clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata)
  );

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Closing report and verdict
  task automatic end_sim();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare one 32-bit result
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Bounded wait: b < 0 waits for start-up to end, else for flag bit b
  task automatic wait_until(input int b);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if ((b < 0 && startup_busy === 1'b0) || (b >= 0 && event_flags[b] === 1'b1)) return;
    end
    fails++;
    $display("ERROR wait bit %0d timed out", b);
    end_sim();
  endtask

  // Drive one event source: 0-13 are pulses, 14-22 are levels
  task automatic drive(input int n, input logic v);
    case (n) inside
      [0:2]: curr_zx[n] <= v;
      3: comb_zx <= v;
      [4:6]: volt_zx[n-4] <= v;
      [7:9]: zx_tmo[n-7] <= v;
      10: order_err <= v;
      [11:13]: oc[n-11] <= v;
      [14:16]: sag[n-14] <= v;
      [17:19]: ovolt[n-17] <= v;
      default: idle[n-20] <= v;
    endcase
  endtask

  // Flag word bit position of each event source
  function automatic int bit_of(input int n);
    if (n < 3) return 13 + n;
    if (n == 3) return 12;
    if (n < 7) return 5 + n;
    if (n < 10) return n - 1;
    if (n == 10) return 18;
    if (n < 14) return 17;
    if (n < 17) return n + 9;
    if (n < 20) return n + 3;
    return 5;
  endfunction

  // Reset release, start-up and the flag state that follows it
  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("flags_in_reset", `FLAGS_RESET, event_flags);
    chk("busy_in_reset", 32'h0000_0001, {31'h0, startup_busy});
    // Release on an edge so reset is sampled high at exactly four edges
    @(posedge clk);
    rst <= 1'b0;
    wait_until(-1);
    host_u.read(`ADDR_FLAGS, r);
    chk("flags_after_startup", 32'h0001_0000, r);
    host_u.write(`ADDR_FLAGS, 32'h0001_0000);
    host_u.read(`ADDR_FLAGS, r);
    chk("flags_cleared", 32'h0000_0000, r);
  endtask

  // Main sequence
  initial begin
    clk_en = 1'b1;
    cfg_image = 64'h1234_5678_9ABC_DEF0;
    {sag, ovolt, idle, oc, curr_zx, volt_zx, zx_tmo} = 21'h00_0000;
    comb_zx = 1'b0;
    order_err = 1'b0;
    pmode = flag_bank_pkg::full_operation_mode;
    fails = 0;
    tests_run = 0;
    do_reset();
    // Every event source, levels both on entry and on exit
    for (k = 0; k < 23; k++) begin
      for (p = 0; p < ((k < 14) ? 1 : 2); p++) begin
        @(posedge clk);
        drive(k, p == 0);
        if (k < 14) begin
          @(posedge clk);
          drive(k, 1'b0);
        end
        host_u.read(`ADDR_FLAGS, r);
        chk("event_flag", 32'h0000_0001 << bit_of(k), r);
        if (k >= 11 && k < 14) begin
          host_u.read(`ADDR_OC_PHASE, r);
          chk("oc_phase", 32'h0000_0001 << (k - 11), r);
          host_u.write(`ADDR_OC_PHASE, 32'h0000_0007);
        end
        if (k >= 20) begin
          host_u.read(`ADDR_IDLE_PHASE, r);
          chk("idle_phase", (p == 0) ? 32'h0000_0001 << (k - 20) : 32'h0000_0000, r);
        end
        if (k == 0) begin
          host_u.write(`ADDR_FLAGS, 32'h0000_0000);
          host_u.read(`ADDR_FLAGS, r);
          chk("zero_write_keeps", 32'h0000_2000, r);
        end
        host_u.write(`ADDR_FLAGS, 32'hFFFF_FFFF);
        host_u.read(`ADDR_FLAGS, r);
        chk("all_cleared", 32'h0000_0000, r);
      end
    end
    // New event in the same cycle as its clear
    fork
      host_u.write(`ADDR_FLAGS, 32'h0000_2000);
      begin
        @(posedge clk);
        curr_zx[0] <= 1'b1;
        @(posedge clk);
        curr_zx[0] <= 1'b0;
      end
    join
    host_u.read(`ADDR_FLAGS, r);
    chk("set_beats_clear", 32'h0000_2000, r);
    host_u.write(`ADDR_FLAGS, 32'hFFFF_FFFF);
    host_u.read(16'h0000, r);
    chk("unmapped_read", 32'h0000_0000, r);
    // Forced checksum run, then a configuration change
    host_u.write(`ADDR_CK_FORCE, 32'h0000_0001);
    wait_until(`BIT_CK_DONE);
    host_u.read(`ADDR_FLAGS, r);
    chk("ck_done", 32'h0800_0000, r);
    host_u.read(`ADDR_CK_RESULT, r0);
    host_u.write(`ADDR_FLAGS, 32'hFFFF_FFFF);
    @(posedge clk);
    cfg_image <= 64'h0F0F_0000_0000_0001;
    wait_until(`BIT_CFG_CHG);
    host_u.read(`ADDR_CK_RESULT, r1);
    chk("ck_result_moved", 32'h0000_0001, {31'h0, r1 !== r0});
    // Seed all ones, rotate left by one, fold in word 0 then word 1
    chk("ck_result_first", 32'hD8B2_1466, r0);
    chk("ck_result_second", 32'hF0F0_FFFD, r1);
    host_u.read(`ADDR_FLAGS, r);
    chk("cfg_changed", 32'h0400_0000, r);
    host_u.write(`ADDR_FLAGS, 32'hFFFF_FFFF);
    // Start-up again on return from the lowest power mode
    @(posedge clk);
    pmode <= flag_bank_pkg::lowest_power_mode;
    repeat (3) @(posedge clk);
    pmode <= flag_bank_pkg::full_operation_mode;
    repeat (2) @(posedge clk);
    #1;
    chk("busy_restart", 32'h0000_0001, {31'h0, startup_busy});
    wait_until(-1);
    chk("powerup_again", 32'h0001_0000, event_flags);
    // An event while the clock enable is low is lost and nothing moves
    @(posedge clk);
    clk_en <= 1'b0;
    curr_zx[1] <= 1'b1;
    @(posedge clk);
    curr_zx[1] <= 1'b0;
    @(posedge clk);
    clk_en <= 1'b1;
    #1;
    chk("frozen_flags", 32'h0001_0000, event_flags);
    // Reset in mid-run with a flag standing
    @(posedge clk);
    comb_zx <= 1'b1;
    @(posedge clk);
    comb_zx <= 1'b0;
    #1;
    chk("flag_before_reset", 32'h0001_1000, event_flags);
    @(posedge clk);
    do_reset();
    end_sim();
  end
endmodule

`default_nettype wire
